// [design/shrm_consts.svh]
`ifndef SHRM_CONSTS_SVH
`define SHRM_CONSTS_SVH
`define SHRM_ADDR_TIME_HI 16'h0004
`define SHRM_ADDR_TIME_LO 16'h0005
`define SHRM_ADDR_ERRORS 16'h0007
`define SHRM_ADDR_HEALTH 16'h0009
`define SHRM_ADDR_SPEED 16'h000a
`define SHRM_ADDR_DIR 16'h000b
`define SHRM_ADDR_CURRENT 16'h000c
`define SHRM_TIME_HI_SHIFT 16
`define SHRM_ERR_GPS_BIT 0
`define SHRM_ERR_MOTOR_BIT 2
`define SHRM_ERR_ANALOG_BIT 3
`define SHRM_HLTH_HEALTHY 16'h0000
`define SHRM_HLTH_ANTIJAM 16'h0001
`define SHRM_HLTH_MOTOR_COMM 16'h0003
`define SHRM_HLTH_HIGH_CUR 16'h0010
`define SHRM_HLTH_TEMP 16'h0030
`define SHRM_HLTH_SUPPLY 16'h0040
`define SHRM_HLTH_ACQUIRE 16'h0100
`define SHRM_DIR_STOP 16'h0000
`define SHRM_DIR_FWD 16'h0001
`define SHRM_DIR_REV 16'h0003
`define SHRM_RESET_WORD 16'h0000
`endif

// [design/shrm_pkg.sv]
package shrm_pkg;
  typedef enum logic [2:0]
  {
    SHRM_IDLE = 3'b001,
    SHRM_HI = 3'b010,
    SHRM_LO = 3'b100
  } shrm_rd_state_t;
  typedef logic [15:0] shrm_word_t;
endpackage

// [design/shrm_health_encode.sv]
`timescale 1ns/1ps
`include "shrm_consts.svh"
// picks the health indicator code from condition inputs, highest priority first
module shrm_health_encode
(
  // conditions
  input wire logic motor_comm_err,
  input wire logic aux_output_on,
  input wire logic high_current,
  input wire logic temp_out_of_range,
  input wire logic supply_out_of_range,
  input wire logic anti_jam,
  input wire logic gps_acquiring,
  // code
  output logic [15:0] code
);
  always_comb
  begin
    if (motor_comm_err && aux_output_on)
      code = `SHRM_HLTH_MOTOR_COMM;
    else if (high_current)
      code = `SHRM_HLTH_HIGH_CUR;
    else if (temp_out_of_range)
      code = `SHRM_HLTH_TEMP;
    else if (supply_out_of_range)
      code = `SHRM_HLTH_SUPPLY;
    else if (anti_jam)
      code = `SHRM_HLTH_ANTIJAM;
    else if (gps_acquiring)
      code = `SHRM_HLTH_ACQUIRE;
    else
      code = `SHRM_HLTH_HEALTHY;
  end
endmodule

// [design/shrm_status_map.sv]
`timescale 1ns/1ps
`include "shrm_consts.svh"
// read-only status map behind the serial slave's register read port
module shrm_status_map
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // time source
  input wire logic [31:0] gps_seconds,
  input wire logic gps_seconds_valid,
  // motor telemetry
  input wire logic [15:0] motor_speed_centi_rpm,
  input wire logic motor_running,
  input wire logic motor_reverse,
  input wire logic [15:0] motor_current_ma,
  // health conditions
  input wire logic gps_comm_err,
  input wire logic motor_comm_err,
  input wire logic analog_out_of_range,
  input wire logic aux_output_on,
  input wire logic high_current,
  input wire logic temp_out_of_range,
  input wire logic supply_out_of_range,
  input wire logic anti_jam,
  input wire logic gps_acquiring,
  // register read port from the frame engine
  input wire logic rd_start,
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic wr_req,
  output logic [15:0] rd_data,
  output logic rd_valid
);
  shrm_pkg::shrm_word_t time_hi_reg;
  shrm_pkg::shrm_word_t time_lo_reg;
  shrm_pkg::shrm_word_t snap_hi_reg;
  shrm_pkg::shrm_word_t snap_lo_reg;
  shrm_pkg::shrm_word_t errors_reg;
  shrm_pkg::shrm_word_t health_reg;
  shrm_pkg::shrm_word_t speed_reg;
  shrm_pkg::shrm_word_t dir_reg;
  shrm_pkg::shrm_word_t current_reg;
  shrm_pkg::shrm_word_t health_next;
  shrm_pkg::shrm_word_t dir_next;
  shrm_pkg::shrm_word_t errors_next;
  shrm_pkg::shrm_word_t rd_next;
  shrm_pkg::shrm_rd_state_t state_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;

  shrm_health_encode u_health
  (
    .motor_comm_err(motor_comm_err),
    .aux_output_on(aux_output_on),
    .high_current(high_current),
    .temp_out_of_range(temp_out_of_range),
    .supply_out_of_range(supply_out_of_range),
    .anti_jam(anti_jam),
    .gps_acquiring(gps_acquiring),
    .code(health_next)
  );

  // live time words, loaded together from the receiver
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      time_hi_reg <= `SHRM_RESET_WORD;
      time_lo_reg <= `SHRM_RESET_WORD;
    end
    else if (gps_seconds_valid)
    begin
      time_hi_reg <= gps_seconds[31:`SHRM_TIME_HI_SHIFT];
      time_lo_reg <= gps_seconds[15:0];
    end
  end

  // snapshot at request start so both halves share one second
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      snap_hi_reg <= `SHRM_RESET_WORD;
      snap_lo_reg <= `SHRM_RESET_WORD;
    end
    else if (rd_start)
    begin
      snap_hi_reg <= time_hi_reg;
      snap_lo_reg <= time_lo_reg;
    end
  end

  always_comb
  begin
    errors_next = `SHRM_RESET_WORD;
    errors_next[`SHRM_ERR_GPS_BIT] = gps_comm_err;
    errors_next[`SHRM_ERR_MOTOR_BIT] = motor_comm_err;
    errors_next[`SHRM_ERR_ANALOG_BIT] = analog_out_of_range;
  end

  always_comb
  begin
    if (!motor_running)
      dir_next = `SHRM_DIR_STOP;
    else if (motor_reverse)
      dir_next = `SHRM_DIR_REV;
    else
      dir_next = `SHRM_DIR_FWD;
  end

  // status words refreshed every cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      errors_reg <= `SHRM_RESET_WORD;
      health_reg <= `SHRM_HLTH_HEALTHY;
      speed_reg <= `SHRM_RESET_WORD;
      dir_reg <= `SHRM_DIR_STOP;
      current_reg <= `SHRM_RESET_WORD;
    end
    else
    begin
      errors_reg <= errors_next;
      health_reg <= health_next;
      speed_reg <= motor_speed_centi_rpm;
      dir_reg <= dir_next;
      current_reg <= motor_current_ma;
    end
  end

  // tracks which time half the current request last asked for
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= shrm_pkg::SHRM_IDLE;
    else if (rd_start)
      state_reg <= shrm_pkg::SHRM_IDLE;
    else if (rd_req && rd_addr == `SHRM_ADDR_TIME_HI)
      state_reg <= shrm_pkg::SHRM_HI;
    else if (rd_req && rd_addr == `SHRM_ADDR_TIME_LO)
      state_reg <= shrm_pkg::SHRM_LO;
  end

  always_comb
  begin
    unique case (rd_addr)
      `SHRM_ADDR_TIME_HI: rd_next = snap_hi_reg;
      `SHRM_ADDR_TIME_LO: rd_next = snap_lo_reg;
      `SHRM_ADDR_ERRORS: rd_next = errors_reg;
      `SHRM_ADDR_HEALTH: rd_next = health_reg;
      `SHRM_ADDR_SPEED: rd_next = speed_reg;
      `SHRM_ADDR_DIR: rd_next = dir_reg;
      `SHRM_ADDR_CURRENT: rd_next = current_reg;
      default: rd_next = `SHRM_RESET_WORD;
    endcase
  end

  // one word answered one cycle after each request; writes change nothing
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_reg <= `SHRM_RESET_WORD;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_req && !wr_req;
      if (rd_req && !wr_req)
        rd_data_reg <= rd_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  a_read_latency: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req |=> rd_valid)
    else $error("read not answered in one cycle");
  a_write_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_req |=> !rd_valid)
    else $error("write produced an answer");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && (rd_addr == 16'h0006 || rd_addr > `SHRM_ADDR_CURRENT)
    |=> rd_data == 16'h0000)
    else $error("unmapped address not zero");
  a_time_join: assert property (@(posedge sys_clk) disable iff (!resetn)
    gps_seconds_valid |=> {time_hi_reg, time_lo_reg} == $past(gps_seconds))
    else $error("time words not split correctly");
  a_snap_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rd_start |=> $stable(snap_hi_reg) && $stable(snap_lo_reg))
    else $error("time snapshot moved inside a request");
  a_motor_prio: assert property (@(posedge sys_clk) disable iff (!resetn)
    motor_comm_err && aux_output_on |=> health_reg == 16'h0003)
    else $error("motor comm code lost precedence");
  a_aux_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
    !aux_output_on |=> health_reg != 16'h0003)
    else $error("motor comm shown with auxiliary off");
  a_error_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    !gps_comm_err && !motor_comm_err && !analog_out_of_range |=> errors_reg == 16'h0000)
    else $error("error word nonzero when healthy");
  a_error_sum: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 errors_reg == ({15'h0000, $past(gps_comm_err)} + {13'h0000, $past(motor_comm_err), 2'h0}
    + {12'h000, $past(analog_out_of_range), 3'h0}))
    else $error("error word not sum of weights");
  a_dir_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    motor_running && motor_reverse |=> dir_reg == 16'h0003)
    else $error("reverse direction code wrong");
  a_speed_copy: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> speed_reg == $past(motor_speed_centi_rpm))
    else $error("speed not tracked");

  // answer path
  a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(rd_req && !wr_req) |=> !rd_valid)
    else $error("answer without a read request");
  a_data_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(rd_req && !wr_req) |=> $stable(rd_data))
    else $error("answer word moved without a read");
  a_write_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_req |=> $stable(rd_data))
    else $error("write disturbed the answer word");
  a_unmapped_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && (rd_addr < `SHRM_ADDR_TIME_HI || rd_addr == 16'h0008)
    |=> rd_data == 16'h0000)
    else $error("unmapped low address not zero");

  // time words and snapshot
  a_time_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !gps_seconds_valid |=> $stable(time_hi_reg) && $stable(time_lo_reg))
    else $error("time words moved without a load");
  a_snap_take: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_start
    |=> snap_hi_reg == $past(time_hi_reg) && snap_lo_reg == $past(time_lo_reg))
    else $error("snapshot not taken at request start");
  a_read_hi: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_TIME_HI |=> rd_data == $past(snap_hi_reg))
    else $error("high time word not returned");
  a_read_lo: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_TIME_LO |=> rd_data == $past(snap_lo_reg))
    else $error("low time word not returned");
  a_state_hi: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !rd_start && rd_addr == `SHRM_ADDR_TIME_HI |=> state_reg == shrm_pkg::SHRM_HI)
    else $error("high half not tracked");
  a_state_lo: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !rd_start && rd_addr == `SHRM_ADDR_TIME_LO |=> state_reg == shrm_pkg::SHRM_LO)
    else $error("low half not tracked");
  a_pair_same: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == shrm_pkg::SHRM_HI && !rd_start && rd_req && !wr_req
    && rd_addr == `SHRM_ADDR_TIME_LO
    |=> rd_data == $past(snap_lo_reg) && $stable(snap_hi_reg))
    else $error("time halves of one request disagree");

  // health code priority
  a_health_ok: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && !high_current && !temp_out_of_range
    && !supply_out_of_range && !anti_jam && !gps_acquiring
    |=> health_reg == 16'h0000)
    else $error("healthy code wrong");
  a_health_acq: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && !high_current && !temp_out_of_range
    && !supply_out_of_range && !anti_jam && gps_acquiring
    |=> health_reg == 16'h0100)
    else $error("acquiring code wrong");
  a_health_jam: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && !high_current && !temp_out_of_range
    && !supply_out_of_range && anti_jam |=> health_reg == 16'h0001)
    else $error("anti-jam code wrong");
  a_health_cur: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && high_current |=> health_reg == 16'h0010)
    else $error("high current code wrong");
  a_health_temp: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && !high_current && temp_out_of_range
    |=> health_reg == 16'h0030)
    else $error("temperature code wrong");
  a_health_supply: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(motor_comm_err && aux_output_on) && !high_current && !temp_out_of_range
    && supply_out_of_range |=> health_reg == 16'h0040)
    else $error("supply code wrong");

  // direction, current and error word
  a_dir_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    !motor_running |=> dir_reg == 16'h0000)
    else $error("stopped direction code wrong");
  a_dir_fwd: assert property (@(posedge sys_clk) disable iff (!resetn)
    motor_running && !motor_reverse |=> dir_reg == 16'h0001)
    else $error("forward direction code wrong");
  a_current_copy: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> current_reg == $past(motor_current_ma))
    else $error("current not tracked");
  a_error_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> errors_reg[0] == $past(gps_comm_err)
    && errors_reg[2] == $past(motor_comm_err)
    && errors_reg[3] == $past(analog_out_of_range))
    else $error("error bit in wrong position");
  a_error_spare: assert property (@(posedge sys_clk) disable iff (!resetn)
    errors_reg[15:4] == 12'h000 && !errors_reg[1])
    else $error("unused error bit set");

  // words returned by the read port
  a_read_errors: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_ERRORS |=> rd_data == $past(errors_reg))
    else $error("error word not returned");
  a_read_health: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_HEALTH |=> rd_data == $past(health_reg))
    else $error("health code not returned");
  a_read_speed: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_SPEED |=> rd_data == $past(speed_reg))
    else $error("speed not returned");
  a_read_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_DIR |=> rd_data == $past(dir_reg))
    else $error("direction not returned");
  a_read_current: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_req && !wr_req && rd_addr == `SHRM_ADDR_CURRENT |=> rd_data == $past(current_reg))
    else $error("current not returned");
endmodule

// [test/shrm_poll_master.sv]
`timescale 1ns/1ps
// frame-engine side of the polling master: snapshot, then one word per cycle
module shrm_poll_master
(
  // clock
  input wire logic sys_clk,
  // command from the bench
  input wire logic go,
  input wire logic [15:0] base,
  input wire logic [3:0] nwords,
  // read port
  output logic rd_start,
  output logic rd_req,
  output logic [15:0] rd_addr
);
  logic [3:0] left;
  initial
  begin
    rd_start = 1'b0;
    rd_req = 1'b0;
    rd_addr = 16'h0000;
    left = 4'h0;
  end
  always @(negedge sys_clk)
  begin
    rd_start <= go;
    rd_req <= (left != 4'h0);
    if (go)
    begin
      left <= nwords;
      rd_addr <= base - 16'h0001;
    end
    else if (left != 4'h0)
    begin
      left <= left - 4'h1;
      rd_addr <= rd_addr + 16'h0001;
    end
    else
      rd_addr <= ~rd_addr;
  end
endmodule

// [test/tb_shrm_status_map.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_shrm_status_map;
  logic sys_clk = 1'b0, resetn = 1'b0, go = 1'b0, gv = 1'b0, wr_req = 1'b0;
  logic [15:0] base = 16'h0000, spd = 16'h0000, cur = 16'h0000, rd_data;
  logic [3:0] nw = 4'h1;
  logic [31:0] secs = 32'h0000_0000;
  logic [6:0] hv = 7'h00;
  logic [2:0] ev = 3'h0;
  logic [1:0] dv = 2'h0;
  logic rd_start, rd_req, rd_valid;
  logic [15:0] rd_addr;
  logic [15:0] got[$];
  int failures = 0, check_count = 0, cycles = 0;
  logic [6:0] hin[10] = '{7'h00, 7'h40, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h60, 7'h20, 7'h62};
  logic [15:0] hexp[10] = '{16'h0000, 16'h0000, 16'h0100, 16'h0001, 16'h0040, 16'h0030,
    16'h0010, 16'h0003, 16'h0000, 16'h0003};
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  shrm_poll_master u_shrm_poll_master (.sys_clk(sys_clk), .go(go), .base(base), .nwords(nw),
    .rd_start(rd_start), .rd_req(rd_req), .rd_addr(rd_addr));
  shrm_status_map u_shrm_status_map (.sys_clk(sys_clk), .resetn(resetn), .gps_seconds(secs),
    .gps_seconds_valid(gv), .motor_speed_centi_rpm(spd), .motor_running(dv[0]),
    .motor_reverse(dv[1]), .motor_current_ma(cur), .gps_comm_err(ev[0]),
    .motor_comm_err(hv[5]), .analog_out_of_range(ev[2]), .aux_output_on(hv[6]),
    .high_current(hv[4]), .temp_out_of_range(hv[3]), .supply_out_of_range(hv[2]),
    .anti_jam(hv[1]), .gps_acquiring(hv[0]), .rd_start(rd_start), .rd_req(rd_req),
    .rd_addr(rd_addr), .wr_req(wr_req), .rd_data(rd_data), .rd_valid(rd_valid));
  // answers collected at the falling edge, where they have settled
  always @(negedge sys_clk)
  begin
    if (rd_valid === 1'b1)
      got.push_back(rd_data);
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic poll(input logic [15:0] a, input int n);
    got.delete();
    @(negedge sys_clk);
    base = a;
    nw = n[3:0];
    go <= 1'b1;
    @(negedge sys_clk);
    go <= 1'b0;
    repeat (n + 6) @(negedge sys_clk);
    `CHK(got.size(), (wr_req === 1'b1) ? 0 : n)
  endtask
  task automatic test_time();
    logic [31:0] pair;
    @(negedge sys_clk);
    secs = 32'h1234_abcd;
    gv = 1'b1;
    @(negedge sys_clk);
    gv = 1'b0;
    secs = 32'h1234_abce;
    poll(16'h0004, 2);
    `CHK(got[0], 16'h1234)
    `CHK(got[1], 16'habcd)
    // seconds roll over the high word at the edge that takes the request's snapshot, before its two reads
    secs = 32'h1234_fffe;
    gv = 1'b1;
    fork
      poll(16'h0004, 2);
      repeat (4) @(negedge sys_clk) secs = secs + 32'h0000_0001;
    join
    pair = {got[0], got[1]};
    `CHK(pair, 32'h1234_ffff)
    for (int i = 0; i < 3; i++)
    begin
      secs = 32'h0000_fff0 + i;
      poll(16'h0005, 1);
      `CHK(got[0], 16'hfff0 + i[15:0])
    end
  endtask
  task automatic test_health();
    for (int i = 0; i < 10; i++)
    begin
      hv = hin[i];
      poll(16'h0009, 1);
      `CHK(got[0], hexp[i])
    end
    hv = 7'h00;
  endtask
  task automatic test_errors();
    logic [15:0] exp_word;
    for (int i = 0; i < 8; i++)
    begin
      ev = {i[2], 1'b0, i[0]};
      hv = {1'b0, i[1], 5'h00};
      exp_word = (i[0] ? 16'h0001 : 16'h0000) + (i[1] ? 16'h0004 : 16'h0000)
        + (i[2] ? 16'h0008 : 16'h0000);
      poll(16'h0007, 1);
      `CHK(got[0], exp_word)
    end
    ev = 3'h0;
    hv = 7'h00;
  endtask
  task automatic test_motor();
    logic [15:0] dexp[4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0003};
    spd = 16'h2710;
    cur = 16'hffff;
    for (int i = 0; i < 4; i++)
    begin
      dv = i[1:0];
      poll(16'h000a, 3);
      `CHK(got[0], 16'h2710)
      `CHK(got[1], dexp[i])
      `CHK(got[2], 16'hffff)
    end
  endtask
  task automatic test_refuse();
    logic [31:0] pair;
    // time words frozen at the last loaded count
    gv = 1'b0;
    secs = 32'h0000_0000;
    wr_req = 1'b1;
    poll(16'h0004, 2);
    `CHK(rd_data, 16'hffff)
    wr_req = 1'b0;
    poll(16'h0004, 2);
    pair = {got[0], got[1]};
    `CHK(pair, 32'h0000_fff2)
    poll(16'h0006, 3);
    `CHK(got[0], 16'h0000)
    `CHK(got[2], 16'h0000)
  endtask
  task automatic test_reset();
    poll(16'h000c, 1);
    `CHK(got[0], 16'hffff)
    secs = 32'h5555_aaaa;
    resetn = 1'b0;
    @(negedge sys_clk);
    `CHK(rd_valid, 1'b0)
    `CHK(rd_data, 16'h0000)
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    poll(16'h0004, 2);
    `CHK(got[0], 16'h0000)
    `CHK(got[1], 16'h0000)
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    test_time();
    test_health();
    test_errors();
    test_motor();
    test_refuse();
    test_reset();
    give_verdict();
  end
endmodule
